// ### design/cpo_pkg.sv
/*
 * cpo_pkg: shared constants and types for the clock-output and synthesizer
 * pin-override control block.
 * assumes: a single 25 MHz system clock; spi frames of 24 bits, mode 0.
 */
package cpo_pkg;
   // register offsets
   localparam logic [14:0] ADDR_AUX_CTRL  = 15'h0057;
   localparam logic [14:0] ADDR_OVERRIDE  = 15'h0058;
   localparam logic [14:0] ADDR_TRIM      = 15'h0059;
   // reset values
   localparam logic [7:0]  RST_AUX_CTRL   = 8'h00;
   localparam logic [7:0]  RST_OVERRIDE   = 8'h00;
   localparam logic [7:0]  RST_TRIM       = 8'h00;
   // aux output control fields
   localparam int          AUX_EN_BIT     = 7;
   localparam int          AUX_SEL_LSB    = 0;
   localparam int          AUX_SEL_W      = 3;
   // override register fields and trim field width
   localparam int          OVR_EN_BIT     = 7;
   localparam int          OVR_D_LSB      = 4;
   localparam int          OVR_C_LSB      = 2;
   localparam int          OVR_SE_BIT     = 1;
   localparam int          OVR_SYN_BIT    = 0;
   localparam int          TRIM_W         = 7;
   // aux select codes
   localparam logic [2:0]  AUX_SEL_UI16   = 3'h0;
   localparam logic [2:0]  AUX_SEL_UI32   = 3'h1;
   localparam logic [2:0]  AUX_SEL_UI64   = 3'h2;
   localparam logic [2:0]  AUX_SEL_TSTAMP = 3'h3;
   // aux clock periods in serializer unit intervals
   localparam int          UI_PERIOD_16   = 16;
   localparam int          UI_PERIOD_32   = 32;
   localparam int          UI_PERIOD_64   = 64;
   // divided-reference select codes
   localparam logic [1:0]  REF_OFF        = 2'h0;
   localparam logic [1:0]  REF_DIV1       = 2'h1;
   localparam logic [1:0]  REF_DIV2       = 2'h2;
   localparam logic [1:0]  REF_DIV4       = 2'h3;
   // spi frame layout
   localparam int          SPI_HDR_BITS   = 16;
   localparam int          SPI_FRAME_BITS = 24;

   typedef struct packed {
      logic        wr;
      logic [14:0] addr;
      logic [7:0]  wdata;
   } cpo_reg_req_t;

   typedef enum logic [2:0] {
      CPO_SPI_IDLE = 3'b001,
      CPO_SPI_HDR  = 3'b010,
      CPO_SPI_DATA = 3'b100
   } cpo_spi_state_t;
endpackage

// ### design/cpo_spi_slave.sv
/*
 * cpo_spi_slave: spi register port, mode 0, msb first.
 * frame: rw bit (1 = read), 15 address bits, 8 data bits.
 * assumes: pins are asynchronous; sclk is well below clk_sys_in / 4.
 */
`timescale 1ns/1ps
module cpo_spi_slave (
   input  wire logic                  clk_sys_in,
   input  wire logic                  rst_n_in,
   input  wire logic                  spi_sclk_in,
   input  wire logic                  spi_cs_n_in,
   input  wire logic                  spi_mosi_in,
   input  wire logic [7:0]            rd_data_in,
   output cpo_pkg::cpo_reg_req_t      req_out,
   output logic                       req_valid_out,
   output logic [14:0]                rd_addr_out,
   output logic                       spi_miso_out,
   output logic                       spi_miso_oe_out
);
   logic [2:0]                sclk_sync;
   logic [1:0]                cs_sync;
   logic [1:0]                mosi_sync;
   logic [4:0]                bit_cnt;
   logic [15:0]               hdr;
   logic [7:0]                data_sh;
   logic [7:0]                tx_sh;
   cpo_pkg::cpo_spi_state_t   state;
   logic                      rise;
   logic                      fall;
   logic                      active;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; the first stage feeds only the second
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sclk_sync <= 3'h0;
         cs_sync   <= 2'h3;
         mosi_sync <= 2'h0;
      end else begin
         sclk_sync <= {sclk_sync[1:0], spi_sclk_in};
         cs_sync   <= {cs_sync[0], spi_cs_n_in};
         mosi_sync <= {mosi_sync[0], spi_mosi_in};
      end
   end

   assign rise   = sclk_sync[1] & ~sclk_sync[2];
   assign fall   = ~sclk_sync[1] & sclk_sync[2];
   assign active = ~cs_sync[1];
   assign rd_addr_out = hdr[14:0];

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state         <= cpo_pkg::CPO_SPI_IDLE;
         bit_cnt       <= 5'h00;
         hdr           <= 16'h0000;
         data_sh       <= 8'h00;
         req_out       <= '0;
         req_valid_out <= 1'b0;
      end else begin
         req_valid_out <= 1'b0;
         if (!active) begin
            state   <= cpo_pkg::CPO_SPI_IDLE;
            bit_cnt <= 5'h00;
         end else if (rise) begin
            bit_cnt <= bit_cnt + 5'h01;
            case (state)
               cpo_pkg::CPO_SPI_IDLE,
               cpo_pkg::CPO_SPI_HDR: begin
                  hdr   <= {hdr[14:0], mosi_sync[1]};
                  state <= (bit_cnt == 5'(cpo_pkg::SPI_HDR_BITS - 1)) ?
                           cpo_pkg::CPO_SPI_DATA : cpo_pkg::CPO_SPI_HDR;
               end
               cpo_pkg::CPO_SPI_DATA: begin
                  data_sh <= {data_sh[6:0], mosi_sync[1]};
                  if (bit_cnt == 5'(cpo_pkg::SPI_FRAME_BITS - 1)) begin
                     // writes land only when the full frame arrived
                     req_out.wr    <= ~hdr[15];
                     req_out.addr  <= hdr[14:0];
                     req_out.wdata <= {data_sh[6:0], mosi_sync[1]};
                     req_valid_out <= ~hdr[15];
                     state         <= cpo_pkg::CPO_SPI_IDLE;
                  end
               end
               default: state <= cpo_pkg::CPO_SPI_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data leaves on falling edges once the header is complete
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_sh           <= 8'h00;
         spi_miso_out    <= 1'b0;
         spi_miso_oe_out <= 1'b0;
      end else begin
         spi_miso_oe_out <= active;
         if (fall && state == cpo_pkg::CPO_SPI_DATA) begin
            if (bit_cnt == 5'(cpo_pkg::SPI_HDR_BITS)) begin
               spi_miso_out <= rd_data_in[7];
               tx_sh        <= {rd_data_in[6:0], 1'b0};
            end else begin
               spi_miso_out <= tx_sh[7];
               tx_sh        <= {tx_sh[6:0], 1'b0};
            end
         end else if (!active) begin
            spi_miso_out <= 1'b0;
         end
      end
   end
endmodule // cpo_spi_slave

// ### design/cpo_clock_out_ctrl.sv
/*
 * cpo_clock_out_ctrl: aux clock/trigger output, synthesizer pin override,
 * two divided-reference outputs and the oscillator trim register.
 * assumes: ui and reference ticks are one-cycle pulses on clk_sys_in;
 * straps, select pins and timestamp are asynchronous pins.
 */
`timescale 1ns/1ps
module cpo_clock_out_ctrl (
   input  wire logic       clk_sys_in,
   input  wire logic       rst_n_in,
   input  wire logic       spi_sclk_in,
   input  wire logic       spi_cs_n_in,
   input  wire logic       spi_mosi_in,
   input  wire logic       ser_ui_tick_in,
   input  wire logic       ser_reinit_in,
   input  wire logic       timestamp_input_in,
   input  wire logic       ref_tick_in,
   input  wire logic       synth_enable_pin_in,
   input  wire logic       se_ref_select_pin_in,
   input  wire logic       clock_strap_0_in,
   input  wire logic       clock_strap_1_in,
   input  wire logic       cal_load_in,
   input  wire logic [6:0] cal_trim_in,
   output logic            spi_miso_out,
   output logic            spi_miso_oe_out,
   output logic            aux_out_enable_out,
   output logic            aux_clock_output_out,
   output logic            synth_enable_out,
   output logic            se_ref_select_out,
   output logic            divided_ref_out_c_out,
   output logic            divided_ref_out_d_out,
   output logic [6:0]      osc_freq_trim_out
);
   cpo_pkg::cpo_reg_req_t  req;
   logic                   req_valid;
   logic [14:0]            rd_addr;
   logic [7:0]             rd_data;
   logic [7:0]             aux_output_control;
   logic [7:0]             synth_pin_override;
   logic [7:0]             osc_frequency_trim;
   logic [1:0]             ts_sync;
   logic [1:0]             pin_syn_sync;
   logic [1:0]             pin_se_sync;
   logic [1:0]             strap0_sync;
   logic [1:0]             strap1_sync;
   logic [5:0]             ui_cnt;
   logic                   ovr_on;
   logic [2:0]             aux_sel;
   logic [1:0]             ref_sel [2];
   logic                   ref_run [2];
   logic [1:0]             ref_cnt [2];
   logic                   ref_q   [2];

   // half period of the aux clock in ui ticks, minus one
   function automatic logic [5:0] aux_half(input logic [2:0] sel);
      case (sel)
         cpo_pkg::AUX_SEL_UI16: aux_half = 6'(cpo_pkg::UI_PERIOD_16 / 2 - 1);
         cpo_pkg::AUX_SEL_UI32: aux_half = 6'(cpo_pkg::UI_PERIOD_32 / 2 - 1);
         default:               aux_half = 6'(cpo_pkg::UI_PERIOD_64 / 2 - 1);
      endcase
   endfunction

   // reference ticks between toggles, minus one
   function automatic logic [1:0] ref_half(input logic [1:0] sel);
      case (sel)
         cpo_pkg::REF_DIV2: ref_half = 2'h1;
         cpo_pkg::REF_DIV4: ref_half = 2'h3;
         default:           ref_half = 2'h0;
      endcase
   endfunction

   cpo_spi_slave u_spi (
      .clk_sys_in      (clk_sys_in),
      .rst_n_in        (rst_n_in),
      .spi_sclk_in     (spi_sclk_in),
      .spi_cs_n_in     (spi_cs_n_in),
      .spi_mosi_in     (spi_mosi_in),
      .rd_data_in      (rd_data),
      .req_out         (req),
      .req_valid_out   (req_valid),
      .rd_addr_out     (rd_addr),
      .spi_miso_out    (spi_miso_out),
      .spi_miso_oe_out (spi_miso_oe_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ts_sync      <= 2'h0;
         pin_syn_sync <= 2'h0;
         pin_se_sync  <= 2'h0;
         strap0_sync  <= 2'h0;
         strap1_sync  <= 2'h0;
      end else begin
         ts_sync      <= {ts_sync[0], timestamp_input_in};
         pin_syn_sync <= {pin_syn_sync[0], synth_enable_pin_in};
         pin_se_sync  <= {pin_se_sync[0], se_ref_select_pin_in};
         strap0_sync  <= {strap0_sync[0], clock_strap_0_in};
         strap1_sync  <= {strap1_sync[0], clock_strap_1_in};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register file
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         aux_output_control <= cpo_pkg::RST_AUX_CTRL;
         synth_pin_override <= cpo_pkg::RST_OVERRIDE;
         osc_frequency_trim <= cpo_pkg::RST_TRIM;
      end else begin
         if (req_valid && req.wr) begin
            if (req.addr == cpo_pkg::ADDR_AUX_CTRL) begin
               aux_output_control <= req.wdata;
            end else if (req.addr == cpo_pkg::ADDR_OVERRIDE) begin
               synth_pin_override <= req.wdata;
            end else if (req.addr == cpo_pkg::ADDR_TRIM) begin
               osc_frequency_trim <= req.wdata;
            end
         end
         // a calibration load beats a host write to trim bits 6:0 in the same cycle
         if (cal_load_in) begin
            osc_frequency_trim[cpo_pkg::TRIM_W-1:0] <= cal_trim_in;
         end
      end
   end

   always_comb begin
      if (rd_addr == cpo_pkg::ADDR_AUX_CTRL) begin
         rd_data = aux_output_control;
      end else if (rd_addr == cpo_pkg::ADDR_OVERRIDE) begin
         rd_data = synth_pin_override;
      end else if (rd_addr == cpo_pkg::ADDR_TRIM) begin
         rd_data = osc_frequency_trim;
      end else begin
         rd_data = 8'h00;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         osc_freq_trim_out <= 7'h00;
      end else begin
         osc_freq_trim_out <= osc_frequency_trim[cpo_pkg::TRIM_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // synthesizer pin override
   assign ovr_on = synth_pin_override[cpo_pkg::OVR_EN_BIT];

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         synth_enable_out  <= 1'b0;
         se_ref_select_out <= 1'b0;
      end else if (ovr_on) begin
         synth_enable_out  <= synth_pin_override[cpo_pkg::OVR_SYN_BIT];
         se_ref_select_out <= synth_pin_override[cpo_pkg::OVR_SE_BIT];
      end else begin
         synth_enable_out  <= pin_syn_sync[1];
         se_ref_select_out <= pin_se_sync[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // divided-reference outputs c (index 0) and d (index 1)
   always_comb begin
      if (ovr_on) begin
         ref_sel[0] = synth_pin_override[cpo_pkg::OVR_C_LSB +: 2];
         ref_sel[1] = synth_pin_override[cpo_pkg::OVR_D_LSB +: 2];
      end else begin
         ref_sel[0] = {strap1_sync[1], strap0_sync[1]};
         ref_sel[1] = {strap1_sync[1], strap0_sync[1]};
      end
      ref_run[0] = (ref_sel[0] != cpo_pkg::REF_OFF);
      ref_run[1] = (ref_sel[1] != cpo_pkg::REF_OFF) && ref_run[0];
   end

   for (genvar i = 0; i < 2; i++) begin : g_ref
      always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            ref_cnt[i] <= 2'h0;
            ref_q[i]   <= 1'b0;
         end else if (!ref_run[i]) begin
            ref_cnt[i] <= 2'h0;
            ref_q[i]   <= 1'b0;
         end else if (ref_tick_in) begin
            if (ref_cnt[i] >= ref_half(ref_sel[i])) begin
               ref_cnt[i] <= 2'h0;
               ref_q[i]   <= ~ref_q[i];
            end else begin
               ref_cnt[i] <= ref_cnt[i] + 2'h1;
            end
         end
      end
   end

   assign divided_ref_out_c_out = ref_q[0];
   assign divided_ref_out_d_out = ref_q[1];

   ////////////////////////////////////////////////////////////////////////
   // aux output; reserved selects hold it low
   assign aux_sel = aux_output_control[cpo_pkg::AUX_SEL_LSB +: cpo_pkg::AUX_SEL_W];

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         aux_out_enable_out   <= 1'b0;
         aux_clock_output_out <= 1'b0;
         ui_cnt               <= 6'h00;
      end else begin
         aux_out_enable_out <= aux_output_control[cpo_pkg::AUX_EN_BIT];
         if (!aux_output_control[cpo_pkg::AUX_EN_BIT]) begin
            aux_clock_output_out <= 1'b0;
            ui_cnt               <= 6'h00;
         end else if (aux_sel == cpo_pkg::AUX_SEL_TSTAMP) begin
            aux_clock_output_out <= ts_sync[1];
            ui_cnt               <= 6'h00;
         end else if (aux_sel > cpo_pkg::AUX_SEL_TSTAMP) begin
            aux_clock_output_out <= 1'b0;
            ui_cnt               <= 6'h00;
         end else if (ser_reinit_in) begin
            // divided path follows the serializer, so it stops with it
            aux_clock_output_out <= 1'b0;
            ui_cnt               <= 6'h00;
         end else if (ser_ui_tick_in) begin
            if (ui_cnt >= aux_half(aux_sel)) begin
               ui_cnt               <= 6'h00;
               aux_clock_output_out <= ~aux_clock_output_out;
            end else begin
               ui_cnt <= ui_cnt + 6'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_aux_off;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      !aux_output_control[7] |=> !aux_clock_output_out && !aux_out_enable_out;
   endproperty
   a_aux_off: assert property (p_aux_off) else $error("aux output active while disabled");

   property p_aux_tstamp;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (aux_output_control[7] && aux_sel == 3'h3) |=> aux_clock_output_out == $past(ts_sync[1]);
   endproperty
   a_aux_tstamp: assert property (p_aux_tstamp) else $error("aux not following timestamp");

   property p_aux_reserved;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (aux_sel[2] && $stable(aux_sel)) |=> !aux_clock_output_out;
   endproperty
   a_aux_reserved: assert property (p_aux_reserved) else $error("reserved select drives aux");

   property p_aux_reinit;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (ser_reinit_in && aux_sel <= 3'h2) |=> !aux_clock_output_out && ui_cnt == 6'h00;
   endproperty
   a_aux_reinit: assert property (p_aux_reinit) else $error("aux ran during reinit");

   property p_ui16_limit;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (aux_output_control[7] && aux_sel == 3'h0) |-> ui_cnt <= 6'h07;
   endproperty
   a_ui16_limit: assert property (p_ui16_limit) else $error("16 ui counter overran");

   property p_pin_mode;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      !ovr_on |=> synth_enable_out == $past(pin_syn_sync[1])
                  && se_ref_select_out == $past(pin_se_sync[1]);
   endproperty
   a_pin_mode: assert property (p_pin_mode) else $error("pin mode not followed");

   property p_ovr_syn;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      ovr_on |=> synth_enable_out == $past(synth_pin_override[0]);
   endproperty
   a_ovr_syn: assert property (p_ovr_syn) else $error("override enable not applied");

   property p_ovr_se;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      ovr_on |=> se_ref_select_out == $past(synth_pin_override[1]);
   endproperty
   a_ovr_se: assert property (p_ovr_se) else $error("override select not applied");

   property p_d_needs_c;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (ref_sel[0] == 2'h0) |=> !divided_ref_out_d_out;
   endproperty
   a_d_needs_c: assert property (p_d_needs_c) else $error("output d ran without c");

   property p_c_off;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      (ovr_on && synth_pin_override[3:2] == 2'h0) |=> !divided_ref_out_c_out;
   endproperty
   a_c_off: assert property (p_c_off) else $error("output c ran while off");

   property p_cal_load;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      cal_load_in |=> ##1 osc_freq_trim_out == $past(cal_trim_in, 2);
   endproperty
   a_cal_load: assert property (p_cal_load) else $error("calibration trim lost");

   c_aux_toggle: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      aux_output_control[7] && aux_sel == 3'h0 && $rose(aux_clock_output_out));
   c_ref_d_run: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      $rose(divided_ref_out_d_out));
   c_spi_write: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      req_valid && req.addr == cpo_pkg::ADDR_OVERRIDE);
   c_cal_load: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      cal_load_in);
endmodule // cpo_clock_out_ctrl

// ### bench/cpo_spi_host.sv
/* cpo_spi_host: host model on the spi register port, mode 0, msb first.
   assumes: caller waits for each xfer to return; 25 MHz system clock. */
`timescale 1ns/1ps
module cpo_spi_host (
   input  wire logic clk_sys_in,
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      mosi_out,
   input  wire logic miso_in
);
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      mosi_out = 1'b0;
   end
   // six clocks a half period keeps well clear of the 4 clk minimum
   task automatic half();
      repeat (6) @(posedge clk_sys_in);
   endtask
   task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      logic [23:0] f;
      f = {rd, a, d};
      q = 8'h00;
      @(posedge clk_sys_in);
      cs_n_out <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         mosi_out <= f[i];
         half();
         sclk_out <= 1'b1;
         q = {q[6:0], miso_in};
         half();
         sclk_out <= 1'b0;
      end
      half();
      cs_n_out <= 1'b1;
      // released line must not keep showing the last bit
      mosi_out <= ~mosi_out;
      half();
   endtask
endmodule // cpo_spi_host

// ### bench/cpo_clock_out_ctrl_test.sv
/* cpo_clock_out_ctrl_test: self-checking bench for the clock output block.
   assumes: host model on the spi pins; ticks generated here on clk_sys_in. */
`timescale 1ns/1ps
module cpo_clock_out_ctrl_test;
   typedef struct {string n; logic [31:0] v;} cpo_note_t;
   logic clk = 0, rst_n = 0, ui = 0, rein = 0, ts = 0, rt = 0, pen = 0, pse = 0;
   logic s0 = 0, s1 = 0, cl = 0;
   logic [6:0]  ct = 7'h00, trim;
   logic        sclk, cs_n, mosi, miso, oe, miso_w, aen, aux, sen, sse, dc, dd;
   logic [31:0] seed = 32'h9f73, obs, r;
   logic [7:0]  rd;
   int          n_fail = 0, check_count = 0, tc, td, ta;
   cpo_note_t   nq[$];
   event        ev;
   always #20 clk = ~clk;
   // pulled high while the design does not drive the read line
   assign miso_w = oe ? miso : 1'b1;
   cpo_spi_host host_u (.clk_sys_in(clk), .sclk_out(sclk), .cs_n_out(cs_n),
      .mosi_out(mosi), .miso_in(miso_w));
   cpo_clock_out_ctrl dut_u (.clk_sys_in(clk), .rst_n_in(rst_n), .spi_sclk_in(sclk),
      .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .ser_ui_tick_in(ui), .ser_reinit_in(rein),
      .timestamp_input_in(ts), .ref_tick_in(rt), .synth_enable_pin_in(pen),
      .se_ref_select_pin_in(pse), .clock_strap_0_in(s0), .clock_strap_1_in(s1),
      .cal_load_in(cl), .cal_trim_in(ct), .spi_miso_out(miso), .spi_miso_oe_out(oe),
      .aux_out_enable_out(aen), .aux_clock_output_out(aux), .synth_enable_out(sen),
      .se_ref_select_out(sse), .divided_ref_out_c_out(dc), .divided_ref_out_d_out(dd),
      .osc_freq_trim_out(trim));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int tog(int x);
      return (x == 0) ? 0 : (64 >> (x - 1));
   endfunction
   task automatic chk(string n, logic [31:0] e, logic [31:0] s);
      nq.push_back('{n, e});
      obs = s;
      -> ev;
      #1;
   endtask
   always @(ev) begin : mon
      cpo_note_t t;
      t = nq.pop_front();
      check_count++;
      if (t.v !== obs) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", t.n, t.v, obs);
      end
   end
   task automatic wr(logic [14:0] a, logic [7:0] d);
      host_u.xfer(1'b0, a, d, rd);
      repeat (8) @(posedge clk);
   endtask
   task automatic rdchk(logic [14:0] a, logic [7:0] e, string n);
      host_u.xfer(1'b1, a, 8'h00, rd);
      chk(n, {24'h0, e}, {24'h0, rd});
   endtask
   // n ticks on both tick inputs, one every other clock; counts output toggles
   task automatic run(int n);
      logic pc, pd, pa;
      tc = 0; td = 0; ta = 0;
      @(posedge clk);
      #1;
      pc = dc; pd = dd; pa = aux;
      for (int i = 0; i < 2 * n + 2; i++) begin
         @(posedge clk);
         ui <= (i < 2 * n) && !ui;
         rt <= (i < 2 * n) && !rt;
         #1;
         tc += int'(dc !== pc); td += int'(dd !== pd); ta += int'(aux !== pa);
         pc = dc; pd = dd; pa = aux;
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #3ms;
      n_fail++;
      end_sim();
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rdchk(15'h0057, 8'h00, "aux_ctrl_reset");
      rdchk(15'h0058, 8'h00, "override_reset");
      rdchk(15'h0059, 8'h00, "trim_reset");
      rdchk(15'h0060, 8'h00, "unmapped_read");
      @(posedge clk);
      pen <= 1'b1;
      pse <= 1'b1;
      s1  <= 1'b1;
      wr(15'h0058, 8'h3f);
      chk("synth_en_pin", 1, sen);
      chk("se_sel_pin", 1, sse);
      run(64);
      chk("strap_c", 32, tc);
      chk("strap_d", 32, td);
      // second strap code: both outputs at ref/1
      @(posedge clk);
      s0 <= 1'b1;
      s1 <= 1'b0;
      run(16);
      chk("strap_c1", 16, tc);
      chk("strap_d1", 16, td);
      wr(15'h0058, 8'h81);
      chk("synth_en_ovr", 1, sen);
      chk("se_sel_ovr0", 0, sse);
      wr(15'h0058, 8'h82);
      chk("synth_en_ovr0", 0, sen);
      chk("se_sel_ovr", 1, sse);
      for (int k = 0; k < 4; k++) begin
         wr(15'h0058, {2'b10, 2'(3 - k), 2'(k), 2'b00});
         run(64);
         chk("div_c", tog(k), tc);
         chk("div_d", (k == 0) ? 0 : tog(3 - k), td);
      end
      for (int m = 0; m < 3; m++) begin
         wr(15'h0057, 8'(m));
         wr(15'h0057, 8'(8'h80 | m));
         chk("aux_en", 1, aen);
         run(128);
         chk("aux_toggles", 16 >> m, ta);
         wr(15'h0057, 8'(m));
         run(32);
         chk("aux_off", 0, ta);
         chk("aux_en_off", 0, aen);
      end
      // select changes only ever follow a write that clears the enable
      wr(15'h0057, 8'h00);
      wr(15'h0057, 8'h80);
      run(8);
      chk("aux_high", 1, aux);
      @(posedge clk);
      rein <= 1'b1;
      run(16);
      chk("aux_reinit", 0, aux);
      @(posedge clk);
      rein <= 1'b0;
      wr(15'h0057, 8'h00);
      wr(15'h0057, 8'h03);
      wr(15'h0057, 8'h83);
      for (int i = 0; i < 6; i++) begin
         r = rnd();
         @(posedge clk);
         ts <= r[3];
         repeat (6) @(posedge clk);
         chk("aux_tstamp", {31'h0, r[3]}, {31'h0, aux});
      end
      wr(15'h0057, 8'h03);
      wr(15'h0057, 8'h05);
      wr(15'h0057, 8'h85);
      run(64);
      chk("aux_reserved", 0, ta);
      r = rnd();
      // reserved trim bit 7 is written as zero
      wr(15'h0059, {1'b0, r[6:0]});
      rdchk(15'h0059, {1'b0, r[6:0]}, "trim_readback");
      chk("trim_out", {25'h0, r[6:0]}, {25'h0, trim});
      @(posedge clk);
      ct <= r[14:8];
      cl <= 1'b1;
      @(posedge clk);
      cl <= 1'b0;
      repeat (3) @(posedge clk);
      chk("trim_cal", {25'h0, r[14:8]}, {25'h0, trim});
      end_sim();
   end
endmodule // cpo_clock_out_ctrl_test
